// ===== ifs_pkg.sv
// Purpose: shared constants and types for the filter and stamp configuration bank
// Assumes: 8-bit registers reached through the serial interface register port
// Notes:   only bits with a defined function are stored; others read as zero
package ifs_pkg;

  // register addresses
  localparam logic [6:0] ADDR_GYRO_HP_OFS = 7'h16;
  localparam logic [6:0] ADDR_ACC_FILT    = 7'h17;
  localparam logic [6:0] ADDR_PIN_STAMP   = 7'h18;

  // reset values
  localparam logic [7:0] RST_GYRO_HP_OFS = 8'h00;
  localparam logic [7:0] RST_ACC_FILT    = 8'h00;
  localparam logic [7:0] RST_PIN_STAMP   = 8'he0;

  // writable masks; reserved positions stay zero
  localparam logic [7:0] MASK_GYRO_HP_OFS = 8'h72;
  localparam logic [7:0] MASK_ACC_FILT    = 8'hfd;
  localparam logic [7:0] MASK_PIN_STAMP   = 8'hfe;

  // gyro_highpass_and_offset_ctrl fields
  localparam int POS_GYRO_HIGHPASS_ON     = 6;
  localparam int POS_GYRO_HIGHPASS_CUTOFF = 4;
  localparam int POS_USER_OFFSET_APPLY    = 1;

  // accel_filter_ctrl fields
  localparam int POS_ACCEL_CUTOFF_FIELD    = 5;
  localparam int POS_ACCEL_REFERENCE_MODE  = 4;
  localparam int POS_ACCEL_FAST_SETTLE     = 3;
  localparam int POS_SLOPE_HIGHPASS_SELECT = 2;
  localparam int POS_ORIENT_SOURCE_SELECT  = 0;

  // pin_stamp_and_config_ctrl fields
  localparam int POS_STAMP_AXIS_Z        = 5;
  localparam int POS_STAMP_SENSOR_SELECT = 4;
  localparam int POS_STAMP_ACCEL_EXTEND  = 3;
  localparam int POS_STAMP_PIN_POLARITY  = 2;
  localparam int POS_PROPER_CONFIG_BIT   = 1;

  // samples after the power-down exit until fast settling is done
  localparam logic [1:0] FAST_SETTLE_SAMPLES = 2'h2;

  // output-rate divisors for cutoff codes 000..111
  localparam logic [9:0] RATE_DIV_HALF = 10'h002;
  localparam logic [79:0] RATE_DIV_TABLE = {
    10'h320, 10'h190, 10'h0c8, 10'h064, 10'h02d, 10'h014, 10'h00a, 10'h004};

  // gyro high-pass cutoff selection
  typedef enum logic [1:0] {
    GHP_16_MHZ,
    GHP_65_MHZ,
    GHP_260_MHZ,
    GHP_1040_MHZ
  } ifs_gyro_cut_t;

  // accelerometer path actually in use
  typedef enum logic [1:0] {
    ACC_FIRST_LOWPASS,
    ACC_SECOND_LOWPASS,
    ACC_SLOPE,
    ACC_HIGHPASS
  } ifs_acc_path_t;

  // data-enable trigger modes
  typedef enum logic [2:0] {
    TRIG_NONE,
    TRIG_EDGE,
    TRIG_LEVEL,
    TRIG_LEVEL_LATCHED,
    TRIG_LEVEL_FIFO
  } ifs_trig_t;

  typedef struct packed {
    logic [7:0]    gyro_hp_ofs;
    logic [7:0]    acc_filt;
    logic [7:0]    pin_stamp;
    logic [7:0]    rdata;
    logic          den_s1;
    logic          den_s2;
    logic          den_active;
    logic [1:0]    settle_cnt;
    logic          settle_on;
    logic          gyro_hp_active;
    ifs_gyro_cut_t gyro_cut;
    logic          user_offset;
    ifs_acc_path_t acc_path;
    logic [9:0]    acc_div;
    logic [9:0]    lp1_div;
    logic          ref_mode;
    logic          orient_lp2;
    ifs_trig_t     trig_mode;
  } ifs_ctrl_state_t;

endpackage

// ===== ifs_stamp_if.sv
// Purpose: stamp controls passed from the register bank to the stamping unit
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
interface ifs_stamp_if;
  logic       den_active;
  logic [2:0] axis_on;
  logic       sensor_accel;
  logic       accel_extend;

  modport ctrl (output den_active, output axis_on, output sensor_accel, output accel_extend);
  modport unit (input den_active, input axis_on, input sensor_accel, input accel_extend);
endinterface

// ===== ifs_stamp_unit.sv
// Purpose: writes the data-enable pin state into the lsb of selected axes
// Assumes: samples arrive with one-cycle valid strobes on the system clock
// Notes:   adds one cycle of latency to both sensors
`timescale 1ns/10ps
module ifs_stamp_unit #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  input  wire logic          i_ce,
  // controls
  ifs_stamp_if.unit          ctl,
  // samples in
  input  wire logic [3*W-1:0] i_gyro_data,
  input  wire logic          i_gyro_valid,
  input  wire logic [3*W-1:0] i_accel_data,
  input  wire logic          i_accel_valid,
  // samples out
  output logic [3*W-1:0]     o_gyro_data,
  output logic               o_gyro_valid,
  output logic [3*W-1:0]     o_accel_data,
  output logic               o_accel_valid
);

  typedef struct packed {
    logic [3*W-1:0] gyro;
    logic           gyro_v;
    logic [3*W-1:0] accel;
    logic           accel_v;
  } ifs_stamp_state_t;

  ifs_stamp_state_t s_q;
  ifs_stamp_state_t s_d;
  logic [3*W-1:0]   gyro_st;
  logic [3*W-1:0]   accel_st;
  logic             gyro_on;
  logic             accel_on;

  assign gyro_on  = !ctl.sensor_accel;
  assign accel_on = ctl.sensor_accel || ctl.accel_extend;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    // x is the top stamp bit, so axis a maps to bit 2-a
    assign gyro_st[a*W +: W] = {i_gyro_data[a*W+1 +: W-1],
      (gyro_on && ctl.axis_on[2-a]) ? ctl.den_active : i_gyro_data[a*W]};
    assign accel_st[a*W +: W] = {i_accel_data[a*W+1 +: W-1],
      (accel_on && ctl.axis_on[2-a]) ? ctl.den_active : i_accel_data[a*W]};
  end

  always_comb begin
    s_d         = s_q;
    s_d.gyro_v  = i_gyro_valid;
    s_d.accel_v = i_accel_valid;
    if (i_gyro_valid) begin
      s_d.gyro = gyro_st;
    end
    if (i_accel_valid) begin
      s_d.accel = accel_st;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_gyro_data   = s_q.gyro;
  assign o_gyro_valid  = s_q.gyro_v;
  assign o_accel_data  = s_q.accel;
  assign o_accel_valid = s_q.accel_v;

endmodule // ifs_stamp_unit

// ===== ifs_filter_cfg.sv
// Purpose: filter chain and data-enable stamp configuration registers with decode
// Assumes: register port driven by the serial interface logic on the same clock
// Notes:   decoded settings are registered, so they follow a write by one cycle
`timescale 1ns/10ps
module ifs_filter_cfg #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic           i_clk_sys,
  input  wire logic           i_rstn,
  input  wire logic           i_ce,
  // register port
  input  wire logic           i_reg_wr,
  input  wire logic           i_reg_rd,
  input  wire logic [6:0]     i_reg_addr,
  input  wire logic [7:0]     i_reg_wdata,
  output logic [7:0]          o_reg_rdata,
  // state from the rest of the sensor
  input  wire logic           i_gyro_hp_mode,
  input  wire logic           i_accel_second_lowpass_on,
  input  wire logic           i_accel_pd_exit,
  input  wire logic [2:0]     i_trigger_bits,
  // data-enable pin, asynchronous
  input  wire logic           i_data_enable_pin,
  // samples
  input  wire logic [3*W-1:0] i_gyro_data,
  input  wire logic           i_gyro_valid,
  input  wire logic [3*W-1:0] i_accel_data,
  input  wire logic           i_accel_valid,
  output logic [3*W-1:0]      o_gyro_data,
  output logic                o_gyro_valid,
  output logic [3*W-1:0]      o_accel_data,
  output logic                o_accel_valid,
  // decoded filter settings
  output logic                o_gyro_highpass_active,
  output ifs_pkg::ifs_gyro_cut_t o_gyro_highpass_cutoff,
  output logic                o_user_offset_apply,
  output ifs_pkg::ifs_acc_path_t o_accel_path,
  output logic [9:0]          o_accel_rate_div,
  output logic [9:0]          o_first_lowpass_div,
  output logic                o_accel_reference_active,
  output logic                o_accel_fast_settle,
  output logic                o_orientation_source_select,
  output ifs_pkg::ifs_trig_t  o_trigger_mode,
  output logic                o_proper_config_bit
);

  ifs_pkg::ifs_ctrl_state_t s_q;
  ifs_pkg::ifs_ctrl_state_t s_d;
  ifs_stamp_if              stamp_ctl ();
  logic [2:0]               code;
  logic                     slope_sel;
  logic [9:0]               code_div;
  logic                     pol_high;

  assign code      = s_q.acc_filt[ifs_pkg::POS_ACCEL_CUTOFF_FIELD +: 3];
  assign slope_sel = s_q.acc_filt[ifs_pkg::POS_SLOPE_HIGHPASS_SELECT];
  // one table serves both paths; code 000 of the slope path reuses the rate/4 entry
  assign code_div  = ifs_pkg::RATE_DIV_TABLE[code*10 +: 10];
  assign pol_high  = s_q.pin_stamp[ifs_pkg::POS_STAMP_PIN_POLARITY];

  always_comb begin
    s_d = s_q;
    // register writes keep only defined bits; reserved positions are not stored
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ifs_pkg::ADDR_GYRO_HP_OFS: begin
          s_d.gyro_hp_ofs = i_reg_wdata & ifs_pkg::MASK_GYRO_HP_OFS;
        end
        ifs_pkg::ADDR_ACC_FILT: begin
          s_d.acc_filt = i_reg_wdata & ifs_pkg::MASK_ACC_FILT;
        end
        ifs_pkg::ADDR_PIN_STAMP: begin
          s_d.pin_stamp = i_reg_wdata & ifs_pkg::MASK_PIN_STAMP;
        end
        default: ;
      endcase
    end

    // read data is registered and holds until the next read
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ifs_pkg::ADDR_GYRO_HP_OFS: begin
          s_d.rdata = s_q.gyro_hp_ofs;
        end
        ifs_pkg::ADDR_ACC_FILT: begin
          s_d.rdata = s_q.acc_filt;
        end
        ifs_pkg::ADDR_PIN_STAMP: begin
          s_d.rdata = s_q.pin_stamp;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // pin synchroniser, then polarity
    s_d.den_s1     = i_data_enable_pin;
    s_d.den_s2     = s_q.den_s1;
    s_d.den_active = pol_high ? s_q.den_s2 : !s_q.den_s2;

    s_d.gyro_hp_active = s_q.gyro_hp_ofs[ifs_pkg::POS_GYRO_HIGHPASS_ON] && i_gyro_hp_mode;
    s_d.gyro_cut = ifs_pkg::ifs_gyro_cut_t'(
      s_q.gyro_hp_ofs[ifs_pkg::POS_GYRO_HIGHPASS_CUTOFF +: 2]);
    s_d.user_offset = s_q.gyro_hp_ofs[ifs_pkg::POS_USER_OFFSET_APPLY];

    // accelerometer path and cutoff
    if (slope_sel) begin
      s_d.acc_path = (code == 3'h0) ? ifs_pkg::ACC_SLOPE : ifs_pkg::ACC_HIGHPASS;
      s_d.acc_div  = code_div;
    end else if (i_accel_second_lowpass_on) begin
      s_d.acc_path = ifs_pkg::ACC_SECOND_LOWPASS;
      s_d.acc_div  = code_div;
    end else begin
      s_d.acc_path = ifs_pkg::ACC_FIRST_LOWPASS;
      s_d.acc_div  = ifs_pkg::RATE_DIV_HALF;
    end
    // the first output may be wrong after enabling; discarding it is the host's job
    s_d.ref_mode   = s_q.acc_filt[ifs_pkg::POS_ACCEL_REFERENCE_MODE] && slope_sel;
    s_d.orient_lp2 = s_q.acc_filt[ifs_pkg::POS_ORIENT_SOURCE_SELECT];

    // fast settling window is armed only by a power-down exit
    if (i_accel_pd_exit && s_q.acc_filt[ifs_pkg::POS_ACCEL_FAST_SETTLE]) begin
      s_d.settle_cnt = ifs_pkg::FAST_SETTLE_SAMPLES;
    end else if (i_accel_valid && s_q.settle_cnt != 2'h0) begin
      s_d.settle_cnt = s_q.settle_cnt - 2'h1;
    end
    // status kept in its own flop so the output carries no decode glitches
    s_d.settle_on = (s_d.settle_cnt != 2'h0);
    s_d.lp1_div   = ifs_pkg::RATE_DIV_HALF;

    // trigger bits are stored elsewhere; only the mode decode lives here
    unique case (i_trigger_bits)
      3'b100: begin
        s_d.trig_mode = ifs_pkg::TRIG_EDGE;
      end
      3'b010: begin
        s_d.trig_mode = ifs_pkg::TRIG_LEVEL;
      end
      3'b011: begin
        s_d.trig_mode = ifs_pkg::TRIG_LEVEL_LATCHED;
      end
      3'b110: begin
        s_d.trig_mode = ifs_pkg::TRIG_LEVEL_FIFO;
      end
      default: begin
        s_d.trig_mode = ifs_pkg::TRIG_NONE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q             <= '0;
      s_q.gyro_hp_ofs <= ifs_pkg::RST_GYRO_HP_OFS;
      s_q.acc_filt    <= ifs_pkg::RST_ACC_FILT;
      s_q.pin_stamp   <= ifs_pkg::RST_PIN_STAMP;
      // divisors come up at half rate, matching the default first low-pass path
      s_q.acc_div     <= ifs_pkg::RATE_DIV_HALF;
      s_q.lp1_div     <= ifs_pkg::RATE_DIV_HALF;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // stamp controls come from stored bits, so a write never splits a sample
  assign stamp_ctl.den_active   = s_q.den_active;
  assign stamp_ctl.axis_on      = s_q.pin_stamp[ifs_pkg::POS_STAMP_AXIS_Z +: 3];
  assign stamp_ctl.sensor_accel = s_q.pin_stamp[ifs_pkg::POS_STAMP_SENSOR_SELECT];
  assign stamp_ctl.accel_extend = s_q.pin_stamp[ifs_pkg::POS_STAMP_ACCEL_EXTEND];

  // both sensors pass the same one-cycle stage, keeping their relative timing
  ifs_stamp_unit #(
    .W (W)
  ) u_stamp (
    .i_clk_sys     (i_clk_sys),
    .i_rstn        (i_rstn),
    .i_ce          (i_ce),
    .ctl           (stamp_ctl),
    .i_gyro_data   (i_gyro_data),
    .i_gyro_valid  (i_gyro_valid),
    .i_accel_data  (i_accel_data),
    .i_accel_valid (i_accel_valid),
    .o_gyro_data   (o_gyro_data),
    .o_gyro_valid  (o_gyro_valid),
    .o_accel_data  (o_accel_data),
    .o_accel_valid (o_accel_valid)
  );

  assign o_reg_rdata                 = s_q.rdata;
  assign o_gyro_highpass_active      = s_q.gyro_hp_active;
  assign o_gyro_highpass_cutoff      = s_q.gyro_cut;
  assign o_user_offset_apply         = s_q.user_offset;
  assign o_accel_path                = s_q.acc_path;
  assign o_accel_rate_div            = s_q.acc_div;
  assign o_first_lowpass_div         = s_q.lp1_div;
  assign o_accel_reference_active    = s_q.ref_mode;
  assign o_accel_fast_settle         = s_q.settle_on;
  assign o_orientation_source_select = s_q.orient_lp2;
  assign o_trigger_mode              = s_q.trig_mode;
  assign o_proper_config_bit         = s_q.pin_stamp[ifs_pkg::POS_PROPER_CONFIG_BIT];

endmodule // ifs_filter_cfg

// ===== ifs_filter_cfg_checker.sv
// Purpose: concurrent checks on the filter and stamp configuration bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   decoded outputs are judged one enabled edge after their cause
`timescale 1ns/10ps
module ifs_filter_cfg_checker #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic                   i_clk_sys,
  input wire logic                   i_rstn,
  input wire logic                   i_ce,
  // watched ports
  input wire logic                   i_reg_wr,
  input wire logic                   i_reg_rd,
  input wire logic [6:0]             i_reg_addr,
  input wire logic [7:0]             i_reg_wdata,
  input wire logic [7:0]             o_reg_rdata,
  input wire logic                   i_gyro_hp_mode,
  input wire logic [2:0]             i_trigger_bits,
  input wire logic                   i_accel_pd_exit,
  input wire logic [3*W-1:0]         i_gyro_data,
  input wire logic                   i_gyro_valid,
  input wire logic [3*W-1:0]         o_gyro_data,
  input wire logic                   o_gyro_valid,
  input wire logic                   o_gyro_highpass_active,
  input wire ifs_pkg::ifs_acc_path_t o_accel_path,
  input wire logic [9:0]             o_accel_rate_div,
  input wire logic [9:0]             o_first_lowpass_div,
  input wire logic                   o_accel_reference_active,
  input wire logic                   o_accel_fast_settle,
  input wire ifs_pkg::ifs_trig_t     o_trigger_mode
);
  // only the lsb of each axis may differ from the incoming sample
  localparam logic [3*W-1:0] KEEP = ~{{W-1{1'b0}}, 1'b1, {W-1{1'b0}}, 1'b1, {W-1{1'b0}}, 1'b1};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  gyro_hp_gate_a: assert property ($past(i_ce) && !$past(i_gyro_hp_mode) |-> !o_gyro_highpass_active)
    else $error("gyro high-pass active outside high-performance mode");
  ref_needs_slope_a: assert property (o_accel_reference_active |-> o_accel_path inside {ifs_pkg::ACC_SLOPE, ifs_pkg::ACC_HIGHPASS})
    else $error("reference mode active on a low-pass path");
  slope_div_a: assert property (o_accel_path == ifs_pkg::ACC_SLOPE |-> o_accel_rate_div == 10'h004)
    else $error("slope path not at rate/4");
  half_rate_div_a: assert property (o_first_lowpass_div == 10'h002 && (o_accel_path != ifs_pkg::ACC_FIRST_LOWPASS || o_accel_rate_div == 10'h002))
    else $error("first low-pass divisor not two");
  write_read_back_a: assert property (i_ce && i_reg_wr && i_reg_addr == ifs_pkg::ADDR_ACC_FILT ##1 i_ce && i_reg_rd && i_reg_addr == ifs_pkg::ADDR_ACC_FILT |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hfd))
    else $error("read after write returned wrong byte");
  stamp_valid_a: assert property (i_ce && i_gyro_valid |=> o_gyro_valid)
    else $error("gyro sample not passed on");
  stamp_upper_a: assert property (o_gyro_valid && $past(i_ce) |-> ((o_gyro_data ^ $past(i_gyro_data)) & KEEP) == '0)
    else $error("gyro sample altered above the lsb");
  trig_edge_a: assert property ($past(i_ce) && $past(i_trigger_bits) == 3'b100 |-> o_trigger_mode == ifs_pkg::TRIG_EDGE)
    else $error("edge trigger code not decoded");
  settle_cause_a: assert property ($rose(o_accel_fast_settle) |-> $past(i_accel_pd_exit))
    else $error("fast settling without power-down exit");
  cover property (o_accel_path == ifs_pkg::ACC_SLOPE);
  cover property (o_gyro_valid);
  cover property ($rose(o_accel_fast_settle));
endmodule // ifs_filter_cfg_checker

bind ifs_filter_cfg ifs_filter_cfg_checker #(.W(W)) ifs_filter_cfg_checker_i (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_gyro_hp_mode(i_gyro_hp_mode), .i_trigger_bits(i_trigger_bits),
  .i_accel_pd_exit(i_accel_pd_exit), .i_gyro_data(i_gyro_data), .i_gyro_valid(i_gyro_valid),
  .o_gyro_data(o_gyro_data), .o_gyro_valid(o_gyro_valid),
  .o_gyro_highpass_active(o_gyro_highpass_active), .o_accel_path(o_accel_path),
  .o_accel_rate_div(o_accel_rate_div), .o_first_lowpass_div(o_first_lowpass_div),
  .o_accel_reference_active(o_accel_reference_active),
  .o_accel_fast_settle(o_accel_fast_settle), .o_trigger_mode(o_trigger_mode));

// ===== ifs_host_model.sv
// Purpose: host side of the register port, single-byte writes and reads
// Assumes: each task is entered 1 ns after a rising edge
// Notes:   raw lets a test write reserved bits on purpose
`timescale 1ns/10ps
module ifs_host_model (
  // clock
  input  wire logic  i_clk_sys,
  // register port
  output logic       o_wr,
  output logic       o_rd,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata
);
  bit raw = 0;
  initial begin
    o_wr = 0;
    o_rd = 0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end
  task automatic xfer(input bit w, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == 7'h16) ? 8'h72 : (a == 7'h17) ? 8'hfd : 8'hfe;
    if (!raw) d = (d & m) | ((a == 7'h18) ? 8'h02 : 8'h00);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk_sys);
    #1;
  endtask
  // released address and data lines never keep their last value; both strobes go low
  task automatic idle;
    o_wr = 0;
    o_rd = 0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
endmodule // ifs_host_model

// ===== tb_top.sv
// Purpose: self-checking bench for the filter and stamp configuration bank
// Assumes: clock enable high except in one freeze test; inputs change 1 ns after edges
// Notes:   random values come from a fixed seed
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rstn = 0, hp = 0, lp2 = 0, pdx = 0, pin = 0, gv = 0, av = 0, ce = 1;
  logic [2:0] trig = 0;
  logic [47:0] gd = 0, ad = 0, go, ao;
  logic wr, rd, gvo, avo, hpa, ofs, refa, fs, ors, pcb;
  logic [6:0] addr;
  logic [7:0] wd, rdat;
  logic [9:0] div, lp1;
  ifs_pkg::ifs_gyro_cut_t cut;
  ifs_pkg::ifs_acc_path_t path;
  ifs_pkg::ifs_trig_t tm;
  int fails = 0, checks_done = 0, cyc = 0;
  always #20 clk = ~clk;
  ifs_host_model ifs_host_model_i (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wd));
  ifs_filter_cfg #(.W(16)) ifs_filter_cfg_i (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .i_gyro_hp_mode(hp), .i_accel_second_lowpass_on(lp2), .i_accel_pd_exit(pdx),
    .i_trigger_bits(trig), .i_data_enable_pin(pin), .i_gyro_data(gd), .i_gyro_valid(gv),
    .i_accel_data(ad), .i_accel_valid(av), .o_gyro_data(go), .o_gyro_valid(gvo),
    .o_accel_data(ao), .o_accel_valid(avo), .o_gyro_highpass_active(hpa),
    .o_gyro_highpass_cutoff(cut), .o_user_offset_apply(ofs), .o_accel_path(path),
    .o_accel_rate_div(div), .o_first_lowpass_div(lp1), .o_accel_reference_active(refa),
    .o_accel_fast_settle(fs), .o_orientation_source_select(ors), .o_trigger_mode(tm),
    .o_proper_config_bit(pcb));
  task automatic chk(logic [47:0] got, logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wreg(logic [6:0] a, logic [7:0] d);
    ifs_host_model_i.xfer(1, a, d);
  endtask
  task automatic rreg(logic [6:0] a, logic [7:0] e);
    ifs_host_model_i.xfer(0, a, 8'h00);
    chk(rdat, e);
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [11:0] acc_exp(logic [7:0] d, logic l2);
    logic [9:0] t [8] = '{10'h004, 10'h00a, 10'h014, 10'h02d, 10'h064, 10'h0c8, 10'h190, 10'h320};
    if (d[2]) return {(d[7:5] == 3'h0) ? 2'h2 : 2'h3, t[d[7:5]]};
    return {l2 ? 2'h1 : 2'h0, l2 ? t[d[7:5]] : 10'h002};
  endfunction
  function automatic logic [47:0] stamp(logic [47:0] x, logic [7:0] c, logic on);
    for (int k = 0; k < 3; k++)
      if (on && c[7-k]) x[16*k] = pin ^ !c[2];
    return x;
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    logic [7:0] d;
    static logic [2:0] tc [5] = '{3'b000, 3'b100, 3'b010, 3'b011, 3'b110};
    void'($urandom(80753));
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    step;
    rreg(7'h16, 8'h00);
    rreg(7'h17, 8'h00);
    rreg(7'h18, 8'he0);
    chk(div, 10'h002);
    ifs_host_model_i.raw = 1;
    wreg(7'h19, 8'hff);
    rreg(7'h19, 8'h00);
    for (int i = 0; i < 60; i++) begin
      d = $urandom;
      hp = $urandom;
      lp2 = $urandom;
      if (i % 3 == 0) begin
        wreg(7'h16, d);
        rreg(7'h16, d & 8'h72);
        chk(hpa, d[6] & hp);
        chk(cut, d[5:4]);
        chk(ofs, d[1]);
      end else if (i % 3 == 1) begin
        wreg(7'h17, d);
        rreg(7'h17, d & 8'hfd);
        chk({path, div}, acc_exp(d, lp2));
        chk(refa, d[4] & d[2]);
        chk(ors, d[0]);
        chk(lp1, 10'h002);
      end else begin
        wreg(7'h18, d);
        rreg(7'h18, d & 8'hfe);
        chk(pcb, d[1]);
      end
    end
    ifs_host_model_i.idle;
    for (int i = 0; i < 5; i++) begin
      trig = tc[i];
      step;
      chk(tm, 48'(i));
    end
    ifs_host_model_i.raw = 0;
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      pin = $urandom;
      wreg(7'h18, d);
      ifs_host_model_i.idle;
      repeat (4) step;
      gd = 48'({$urandom, $urandom});
      ad = 48'({$urandom, $urandom});
      gv = 1;
      av = 1;
      step;
      gv = 0;
      av = 0;
      chk(go, stamp(gd, d, !d[4]));
      chk(ao, stamp(ad, d, d[4] | d[3]));
      chk({gvo, avo}, 2'h3);
    end
    // a write while the clock enable is low must leave the register alone
    wreg(7'h16, 8'h00);
    ce = 0;
    wreg(7'h16, 8'h72);
    ifs_host_model_i.idle;
    ce = 1;
    rreg(7'h16, 8'h00);
    wreg(7'h17, 8'h1c);
    ifs_host_model_i.idle;
    pdx = 1;
    step;
    pdx = 0;
    step;
    chk(fs, 1'b1);
    // fast settling stays on for two accelerometer samples after the power-down exit
    av = 1;
    step;
    av = 0;
    chk(fs, 1'b1);
    av = 1;
    step;
    av = 0;
    step;
    chk(fs, 1'b0);
    test_done;
  end
endmodule // tb_top
